// ==== design/clock_buffer_config_regs.sv ====
// configuration byte bank of a nine-output differential clock buffer
// assumes a serial bus slave engine on clk_sys issues byte reads, writes and block reads
`timescale 1ns/1ps
`include "cbuf_regs.svh"

module clock_buffer_config_regs
  import cbuf_pkg::*;
#(
  parameter logic [1:0] DEV_TYPE = 2'h0, // arbitrary value
  parameter logic [5:0] DEV_ID = 6'h2A, // arbitrary value
  parameter logic [1:0] IMP_RST = `CBUF_IMP_100
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pins
  input wire logic power_good_sleep_n,
  input wire logic oe_pin_n,
  // single byte access from the slave engine
  input wire reg_req_type req,
  // block read sequencing
  input wire logic blk_start,
  input wire logic [7:0] blk_idx,
  input wire logic blk_next,
  output logic [7:0] rd_data_q,
  output logic rd_valid_q,
  output logic blk_done_q,
  // per-output enable bits from the enable bytes
  input wire logic [8:0] out_enable,
  // driver controls
  output logic [1:0] output_eight_impedance_q,
  output logic [7:0] imp_low_q,
  output logic keep_config_on_sleep_q,
  output logic [8:0] forced_q,
  output pin_drive_type drive_q
);

  logic [`CBUF_COUNT_MSB:0] read_length_field_q;
  logic [1:0] disabled_pin_state_q;
  logic pg_s1_q, pg_s2_q, pg_prev_q;
  logic oe_s1_q, oe_s2_q;
  logic sleep_clear;
  blk_state_type blk_q;
  logic [7:0] ptr_q;
  logic [`CBUF_COUNT_MSB:0] remain_q;

  // byte seen by the host at an index
  function automatic logic [7:0] read_byte(input logic [7:0] idx);
    case (idx)
      `CBUF_IDX_ID: read_byte = {DEV_TYPE, DEV_ID};
      `CBUF_IDX_COUNT: read_byte = {3'h0, read_length_field_q};
      `CBUF_IDX_SLEEP: read_byte = {1'b1, keep_config_on_sleep_q, 6'h00};
      `CBUF_IDX_IMP8: read_byte = {output_eight_impedance_q, 4'h0, disabled_pin_state_q};
      `CBUF_IDX_IMP03: read_byte = imp_low_q;
      default: read_byte = 8'h00; // reserved eight, nine and bytes outside this bank
    endcase
  endfunction

  // pair drive for a disable-state code
  function automatic pin_drive_type decode_disabled(input logic [1:0] code);
    case (code)
      `CBUF_DIS_LOW_LOW: decode_disabled = '{1'b0, 1'b1, 1'b0, 1'b1};
      `CBUF_DIS_HIZ: decode_disabled = '{1'b0, 1'b0, 1'b0, 1'b0};
      `CBUF_DIS_HIGH_LOW: decode_disabled = '{1'b1, 1'b1, 1'b0, 1'b1};
      default: decode_disabled = '{1'b0, 1'b1, 1'b1, 1'b1};
    endcase
  endfunction

  // pin synchronisers; the second stage is read, plus a power-good delay stage after it for the sleep edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pg_s1_q <= 1'b1;
      pg_s2_q <= 1'b1;
      pg_prev_q <= 1'b1;
      oe_s1_q <= 1'b0;
      oe_s2_q <= 1'b0;
    end else begin
      pg_s1_q <= power_good_sleep_n;
      pg_s2_q <= pg_s1_q;
      pg_prev_q <= pg_s2_q;
      oe_s1_q <= oe_pin_n;
      oe_s2_q <= oe_s1_q;
    end
  end

  assign sleep_clear = pg_prev_q && !pg_s2_q && !keep_config_on_sleep_q;

  // writable fields; sleep clearing overrides a simultaneous write
  always_ff @(posedge clk_sys) begin
    if (rst || sleep_clear) begin
      read_length_field_q <= `CBUF_COUNT_RST;
      output_eight_impedance_q <= IMP_RST;
      imp_low_q <= {4{IMP_RST}};
      disabled_pin_state_q <= `CBUF_DIS_RST;
    end else if (req.wr) begin
      case (req.idx)
        `CBUF_IDX_COUNT: read_length_field_q <= req.wdata[`CBUF_COUNT_MSB:0];
        `CBUF_IDX_IMP8: begin
          output_eight_impedance_q <= req.wdata[`CBUF_IMP8_MSB:`CBUF_IMP8_LSB];
          disabled_pin_state_q <= req.wdata[`CBUF_DIS_MSB:0];
        end
        `CBUF_IDX_IMP03: imp_low_q <= req.wdata;
        // id and reserved bytes ignore writes
        default: ;
      endcase
    end
  end

  // keep bit itself survives sleep
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      keep_config_on_sleep_q <= `CBUF_KEEP_RST;
    end else if (req.wr && req.idx == `CBUF_IDX_SLEEP) begin
      keep_config_on_sleep_q <= req.wdata[`CBUF_KEEP_BIT];
    end
  end

  // single reads and block reads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blk_q <= BLK_IDLE;
      ptr_q <= 8'h00;
      remain_q <= '0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      blk_done_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      blk_done_q <= 1'b0;
      case (blk_q)
        BLK_IDLE: begin
          if (blk_start) begin
            rd_data_q <= {3'h0, read_length_field_q};
            rd_valid_q <= 1'b1;
            ptr_q <= blk_idx;
            remain_q <= read_length_field_q;
            blk_q <= BLK_STREAM;
            blk_done_q <= (read_length_field_q == '0);
            if (read_length_field_q == '0) begin
              blk_q <= BLK_IDLE;
            end
          end else if (req.rd) begin
            rd_data_q <= read_byte(req.idx);
            rd_valid_q <= 1'b1;
          end
        end
        BLK_STREAM: begin
          if (blk_next) begin
            rd_data_q <= read_byte(ptr_q);
            rd_valid_q <= 1'b1;
            ptr_q <= ptr_q + 8'h01;
            remain_q <= remain_q - 5'h01;
            if (remain_q == 5'h01) begin
              blk_done_q <= 1'b1;
              blk_q <= BLK_IDLE;
            end
          end
        end
        default: blk_q <= BLK_IDLE;
      endcase
    end
  end

  // driver controls
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      forced_q <= 9'h1FF;
      drive_q <= decode_disabled(`CBUF_DIS_RST);
    end else begin
      // cleared enable bit or deasserted pin forces disable
      forced_q <= ~out_enable | {9{oe_s2_q}};
      drive_q <= decode_disabled(disabled_pin_state_q);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // block read opened while idle
  sequence blk_open;
    blk_start && blk_q == BLK_IDLE;
  endsequence
  // length byte on the read port
  sequence len_sent;
    rd_valid_q && rd_data_q == {3'h0, $past(read_length_field_q)};
  endsequence
  // last requested data byte of a block
  sequence last_pull;
    blk_q == BLK_STREAM && blk_next && remain_q == 5'h01;
  endsequence
  // plain byte read accepted
  sequence byte_read;
    req.rd && !blk_start && blk_q == BLK_IDLE;
  endsequence

  chk_id_fixed: assert property (
    req.rd && !blk_start && blk_q == BLK_IDLE && req.idx == `CBUF_IDX_ID
    |=> rd_data_q == {DEV_TYPE, DEV_ID}) else $error("id byte wrong");
  chk_read_valid: assert property (
    byte_read |=> rd_valid_q) else $error("byte read not answered");
  chk_length_write: assert property (
    req.wr && req.idx == `CBUF_IDX_COUNT && !sleep_clear
    |=> read_length_field_q == $past(req.wdata[`CBUF_COUNT_MSB:0]))
    else $error("length not written");
  chk_block_count: assert property (
    blk_open |=> remain_q == $past(read_length_field_q))
    else $error("block count not loaded");
  chk_done_last: assert property (
    last_pull |=> blk_done_q && blk_q == BLK_IDLE) else $error("block not ended");
  chk_empty_block: assert property (
    blk_start && blk_q == BLK_IDLE && read_length_field_q == 5'h00
    |=> blk_done_q && blk_q == BLK_IDLE) else $error("empty block not ended");
  chk_length_reset: assert property (
    $past(rst) |-> read_length_field_q == `CBUF_COUNT_RST)
    else $error("length reset wrong");
  chk_rsvd_zero: assert property (
    req.rd && !blk_start && blk_q == BLK_IDLE
    && (req.idx == `CBUF_IDX_RSVD8 || req.idx == `CBUF_IDX_RSVD9)
    |=> rd_data_q == 8'h00) else $error("reserved byte not zero");
  chk_rsvd_ignore: assert property (
    req.wr && (req.idx == `CBUF_IDX_RSVD8 || req.idx == `CBUF_IDX_RSVD9) && !sleep_clear
    |=> $stable(read_length_field_q) && $stable(imp_low_q) && $stable(disabled_pin_state_q))
    else $error("reserved write took effect");
  chk_sleep_restore: assert property (
    sleep_clear |=> imp_low_q == {4{IMP_RST}} && read_length_field_q == `CBUF_COUNT_RST
    && disabled_pin_state_q == `CBUF_DIS_RST) else $error("config not cleared on sleep");
  chk_sleep_keep: assert property (
    pg_prev_q && !pg_s2_q && keep_config_on_sleep_q && !req.wr
    |=> $stable(imp_low_q) && $stable(read_length_field_q)) else $error("config lost");
  chk_keep_write: assert property (
    req.wr && req.idx == `CBUF_IDX_SLEEP
    |=> keep_config_on_sleep_q == $past(req.wdata[`CBUF_KEEP_BIT]))
    else $error("keep bit not written");
  chk_keep_reset: assert property (
    $past(rst) |-> keep_config_on_sleep_q == `CBUF_KEEP_RST)
    else $error("keep bit reset wrong");
  chk_imp_write: assert property (
    req.wr && req.idx == `CBUF_IDX_IMP8 && !sleep_clear
    |=> output_eight_impedance_q == $past(req.wdata[`CBUF_IMP8_MSB:`CBUF_IMP8_LSB]))
    else $error("impedance not written");
  chk_imp_low_write: assert property (
    req.wr && req.idx == `CBUF_IDX_IMP03 && !sleep_clear
    |=> imp_low_q == $past(req.wdata)) else $error("low impedance not written");
  chk_imp_reset: assert property (
    $past(rst) |-> imp_low_q == {4{IMP_RST}} && output_eight_impedance_q == IMP_RST)
    else $error("impedance reset wrong");
  chk_disabled_hiz: assert property (
    disabled_pin_state_q == `CBUF_DIS_HIZ && $past(disabled_pin_state_q) == `CBUF_DIS_HIZ
    |-> !drive_q.true_oe && !drive_q.comp_oe) else $error("hiz state driven");
  chk_disabled_write: assert property (
    req.wr && req.idx == `CBUF_IDX_IMP8 && !sleep_clear
    |=> disabled_pin_state_q == $past(req.wdata[`CBUF_DIS_MSB:0]))
    else $error("disable state not written");
  chk_disabled_reset: assert property (
    $past(rst) |-> !drive_q.true_lvl && drive_q.true_oe
    && !drive_q.comp_lvl && drive_q.comp_oe) else $error("disabled drive reset wrong");
  chk_force_out: assert property (
    !out_enable[8] ##1 !out_enable[8] |-> forced_q[8]) else $error("output not forced");
  // enabled outputs run while pin active
  chk_force_none: assert property (
    out_enable == 9'h1FF && !oe_s2_q |=> forced_q == 9'h000)
    else $error("output forced while enabled");
  // every output forced by its own enable bit
  for (genvar g = 0; g < 9; g++) begin : g_force
    chk_force_each: assert property (@(posedge clk_sys) disable iff (rst)
      !out_enable[g] |=> forced_q[g]) else $error("cleared enable not forced");
  end
  chk_block_len: assert property (
    blk_open |=> len_sent) else $error("length byte not first");
  chk_block_walk: assert property (
    blk_q == BLK_STREAM && blk_next |=> rd_valid_q && ptr_q == $past(ptr_q) + 8'h01)
    else $error("block pointer not advanced");

endmodule

// ==== design/cbuf_regs.svh ====
// register indices, field positions and reset values of the clock buffer config bank
// assumes byte-wide registers addressed by an 8-bit index from the serial slave engine
`ifndef CBUF_REGS_SVH
`define CBUF_REGS_SVH

`define CBUF_IDX_ID 8'h06
`define CBUF_IDX_COUNT 8'h07
`define CBUF_IDX_RSVD8 8'h08
`define CBUF_IDX_RSVD9 8'h09
`define CBUF_IDX_SLEEP 8'h0A
`define CBUF_IDX_IMP8 8'h0B
`define CBUF_IDX_IMP03 8'h0C

`define CBUF_COUNT_MSB 4
`define CBUF_KEEP_BIT 6
`define CBUF_SLEEP_RSVD_BIT 7
`define CBUF_IMP8_MSB 7
`define CBUF_IMP8_LSB 6
`define CBUF_DIS_MSB 1

`define CBUF_COUNT_RST 5'h08
`define CBUF_KEEP_RST 1'b1
`define CBUF_DIS_RST 2'h0
`define CBUF_IMP_100 2'h2
`define CBUF_IMP_85 2'h1
`define CBUF_IMP_33 2'h0

`define CBUF_DIS_LOW_LOW 2'h0
`define CBUF_DIS_HIZ 2'h1
`define CBUF_DIS_HIGH_LOW 2'h2
`define CBUF_DIS_LOW_HIGH 2'h3

`endif

// ==== design/cbuf_pkg.sv ====
// types shared by the clock buffer config bank and its neighbours
// assumes nothing beyond a SystemVerilog compiler
package cbuf_pkg;

  // drive of one differential pair while disabled
  typedef struct packed {
    logic true_lvl;
    logic true_oe;
    logic comp_lvl;
    logic comp_oe;
  } pin_drive_type;

  // register read or write request from the serial slave engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wdata;
  } reg_req_type;

  typedef enum logic [0:0] {
    BLK_IDLE,
    BLK_STREAM
  } blk_state_type;

endpackage

// ==== verif/host_model.sv ====
// host model issuing byte and block accesses to the config bank
// assumes the bank answers with rd_valid_q within four cycles
`timescale 1ns/1ps
module host_model import cbuf_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // requests
  output reg_req_type req,
  output logic blk_start,
  output logic [7:0] blk_idx,
  output logic blk_next,
  // answers
  input wire logic [7:0] rd_data_q,
  input wire logic rd_valid_q,
  input wire logic blk_done_q
);
  logic [7:0] got [0:31];
  logic last_done;
  // idle bus at time zero
  initial begin
    req = '0;
    blk_start = 1'b0;
    blk_idx = 8'h00;
    blk_next = 1'b0;
  end
  // wait for one answer, bounded
  task automatic get(output logic [7:0] d, output logic dn);
    int k;
    k = 0;
    while (rd_valid_q !== 1'b1 && k < 4) begin
      @(negedge clk_sys);
      k++;
    end
    d = rd_valid_q ? rd_data_q : 8'hxx;
    dn = blk_done_q;
  endtask
  // one byte access; released lines show the inverse
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] v,
                      output logic [7:0] d);
    logic dn;
    @(negedge clk_sys);
    req = '{wr: w, rd: !w, idx: i, wdata: v};
    @(negedge clk_sys);
    req = '{wr: 1'b0, rd: 1'b0, idx: ~i, wdata: ~v};
    if (!w) get(d, dn);
  endtask
  task automatic blk(input logic [7:0] i, input int n);
    @(negedge clk_sys);
    blk_start = 1'b1;
    blk_idx = i;
    @(negedge clk_sys);
    blk_start = 1'b0;
    blk_idx = ~i;
    get(got[0], last_done);
    // strobe held high across back-to-back pulls
    blk_next = (n > 0);
    for (int j = 1; j <= n; j++) begin
      @(negedge clk_sys);
      if (j == n) blk_next = 1'b0;
      get(got[j], last_done);
    end
  endtask
endmodule

// ==== verif/clock_buffer_config_regs_bench.sv ====
// self-checking bench for the clock buffer config bank
// assumes host_model drives the request side of the bank
`timescale 1ns/1ps
`include "cbuf_regs.svh"
module clock_buffer_config_regs_bench import cbuf_pkg::*;
;
  localparam logic [1:0] DTYPE = 2'h1; // arbitrary value
  localparam logic [5:0] DID = 6'h15; // arbitrary value
  localparam logic [1:0] IMP = `CBUF_IMP_85;
  logic clk_sys, rst, sleep_n, oe_n, blk_start, blk_next, rd_valid, blk_done, keep;
  logic [7:0] blk_idx, rd_data, imp_low, i8;
  logic [1:0] imp8;
  logic [8:0] out_en, forced;
  logic [31:0] v;
  reg_req_type req;
  pin_drive_type drive;
  logic [7:0] mir [0:15];
  int seed, n, num_errors, n_checks;
  clock_buffer_config_regs #(.DEV_TYPE(DTYPE), .DEV_ID(DID), .IMP_RST(IMP)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .power_good_sleep_n(sleep_n), .oe_pin_n(oe_n),
    .req(req), .blk_start(blk_start), .blk_idx(blk_idx), .blk_next(blk_next),
    .rd_data_q(rd_data), .rd_valid_q(rd_valid), .blk_done_q(blk_done),
    .out_enable(out_en), .output_eight_impedance_q(imp8), .imp_low_q(imp_low),
    .keep_config_on_sleep_q(keep), .forced_q(forced), .drive_q(drive));
  host_model host_u (.clk_sys(clk_sys), .req(req), .blk_start(blk_start),
    .blk_idx(blk_idx), .blk_next(blk_next), .rd_data_q(rd_data),
    .rd_valid_q(rd_valid), .blk_done_q(blk_done));
  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // readback value a write leaves behind
  function automatic logic [7:0] wmask(input logic [7:0] i, input logic [7:0] w);
    case (i)
      8'h07: wmask = {3'h0, w[4:0]};
      8'h0A: wmask = {1'b1, w[6], 6'h00};
      8'h0B: wmask = {w[7:6], 4'h0, w[1:0]};
      8'h0C: wmask = w;
      default: wmask = mir[i[3:0]];
    endcase
  endfunction
  // defaults, keep bit survives
  task automatic clr_mir();
    logic [7:0] k10;
    k10 = mir[10];
    foreach (mir[k]) mir[k] = 8'h00;
    mir[6] = {DTYPE, DID};
    mir[7] = 8'h08;
    mir[10] = k10;
    mir[11] = {IMP, 6'h00};
    mir[12] = {4{IMP}};
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] w);
    logic [7:0] d;
    host_u.xfer(1'b1, i, w, d);
    mir[i[3:0]] = wmask(i, w);
  endtask
  task automatic rd(input logic [7:0] i);
    logic [7:0] d;
    host_u.xfer(1'b0, i, 8'h00, d);
    chk(d, mir[i[3:0]]);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial begin
    #300000;
    num_errors++;
    wrap_up();
  end
  // test sequence
  initial begin
    seed = 51;
    rst = 1'b1;
    sleep_n = 1'b1;
    oe_n = 1'b0;
    out_en = 9'h1FF;
    mir[10] = 8'hC0;
    clr_mir();
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 6; i <= 12; i++) rd(i[7:0]);
    chk(drive, 4'h5);
    $display("reset test done");
    for (int t = 0; t < 4; t++) begin
      n = t == 0 ? 8 : t == 1 ? 0 : 1 + $unsigned($random(seed)) % 5;
      if (t != 0) wr(8'h07, {3'h7, n[4:0]});
      host_u.blk(8'h06 + t[7:0], n);
      chk(host_u.got[0], n[7:0]);
      for (int j = 1; j <= n; j++) chk(host_u.got[j], mir[6 + t + j - 1]);
      chk(host_u.last_done, 1'b1);
    end
    $display("block test done");
    for (int k = 0; k < 24; k++) begin
      v = $random(seed);
      i8 = 8'h06 + v[15:8] % 8'h07;
      wr(i8, v[7:0]);
      rd(i8);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h0B, {c[1:0], 4'h0, c[1:0]});
      wr(8'h0C, {4{c[1:0]}});
      repeat (2) @(negedge clk_sys);
      chk({imp8, imp_low}, {5{c[1:0]}});
      chk({drive.true_oe, drive.comp_oe}, c == 1 ? 2'b00 : 2'b11);
      if (c != 1) chk({drive.true_lvl, drive.comp_lvl}, {c == 2, c == 3});
    end
    $display("field test done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h0A, {1'b0, k[0], 6'h00});
      wr(8'h0B, 8'h43);
      wr(8'h07, 8'h03);
      sleep_n = 1'b0;
      repeat (6) @(negedge clk_sys);
      sleep_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      if (k == 0) clr_mir();
      chk(keep, k[0]);
      for (int i = 7; i <= 12; i++) rd(i[7:0]);
    end
    $display("sleep test done");
    for (int k = 0; k < 8; k++) begin
      v = $random(seed);
      out_en = v[8:0];
      oe_n = v[9];
      repeat (4) @(negedge clk_sys);
      chk(forced, oe_n ? 9'h1FF : {~out_en});
    end
    $display("enable test done");
    // mid-run reset brings every field back
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    mir[10] = 8'hC0;
    clr_mir();
    chk(keep, 1'b1);
    for (int i = 6; i <= 12; i++) rd(i[7:0]);
    $display("second reset test done");
    wrap_up();
  end
endmodule
